//--- design/sadc_pkg.sv
// Purpose : shared constants and carriers for the converter readout block
// Assumes : 100 MHz mclk_in, all host pins asynchronous to it
// Notes   : times kept in their own units, cycle counts derived from them
package sadc_pkg;
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned CLK_PERIOD_NS     = 1000 / CLK_MHZ;
  localparam int unsigned RESULT_W          = 16;
  localparam int unsigned BYTE_W            = 8;
  // timing figures as printed
  localparam int unsigned CONVERT_PULSE_NS  = 40;    // convert / abort low time
  localparam int unsigned BUSY_PD_MAX_NS    = 20;    // busy fall after convert low
  localparam int unsigned PREV_VALID_NS     = 1500;  // prev_data_valid_time
  localparam int unsigned CONV_TIME_NS      = 2000;  // conversion_time, max
  localparam int unsigned DATA_TO_BUSY_NS   = 35;    // result before busy rises
  // derived counts: minimums round up, maximums round down
  localparam int unsigned CONVERT_PULSE_CYC =
    (CONVERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_PD_MAX_CYC   = BUSY_PD_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned PREV_VALID_CYC    =
    (PREV_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_TIME_CYC     = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned DATA_TO_BUSY_CYC  =
    (DATA_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W             = 12;
  // reset value and full-scale codes
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [RESULT_W-1:0] CODE_POS_FS = 16'h7FFF;
  localparam logic [RESULT_W-1:0] CODE_NEG_FS = 16'h8000;

  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_CONV,
    SADC_PUBLISH
  } sadc_state_t;

  // synchronised host pins
  typedef struct packed {
    logic cs_n;
    logic rd_conv;
    logic byte_sel;
  } sadc_pins_t;

  // data bus carrier: value plus enable
  typedef struct packed {
    logic [RESULT_W-1:0] data;
    logic [RESULT_W-1:0] oe;
  } sadc_bus_t;
endpackage

//--- design/sadc_sync.sv
// Purpose : two-flop synchroniser for the host control pins
// Assumes : pins asynchronous to mclk_in
// Notes   : first stage is read by the second stage only
module sadc_sync
  import sadc_pkg::*;
#(
  parameter int unsigned W = 3
) (
  input  wire logic         mclk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sadc_sync_st_t;

  sadc_sync_st_t st_r;
  sadc_sync_st_t st_nxt;

  // shift the pins through two stages
  always_comb begin
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  // both stages start at the idle pin levels so no false edge follows reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_r.meta   <= rst_val_in;
      st_r.stable <= rst_val_in;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;
endmodule

//--- design/sadc_readout.sv
// Purpose : conversion control and parallel result readout of a 16-bit SAR converter
// Assumes : host pins asynchronous, two-flop synchronised; analog core is the
//           sample_in word captured DATA_TO_BUSY_CYC cycles before the conversion time ends
// Notes   : sync latency adds two cycles to every pin-to-pin delay
// Function
// - busy low until result register updated
// - finished result drives all sixteen data lines
// - previous result valid 1.5 us after start
// - convert falling starts, rising enables outputs
// - busy low at most 2 us
// - result on bus 35 ns before busy
// - busy falls within 20 ns of convert; here 20 to 30 ns after the pin, via two sync flops and the state flop
// - convert low 40 ns during busy aborts; here only until the result is captured, not while busy is held for publish
// - drive bus only when selected and reading
// - results in two's complement coding
// - byte select reads result as halves
module sadc_readout
  import sadc_pkg::*;
#(
  parameter int unsigned CONV_CYC  = CONV_TIME_CYC,
  parameter int unsigned VALID_CYC = PREV_VALID_CYC
) (
  input  wire logic                mclk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                cs_n_in,
  input  wire logic                rd_conv_in,
  input  wire logic                byte_sel_in,
  input  wire logic [RESULT_W-1:0] sample_in,
  output logic                     busy_n_out,
  output logic      [RESULT_W-1:0] data_out,
  output logic      [RESULT_W-1:0] data_oe_out,
  output logic                     aborted_out
);
  typedef struct packed {
    sadc_state_t         state;
    logic [CNT_W-1:0]    cnt;        // conversion / publish timer
    logic [CNT_W-1:0]    vcnt;       // previous-result validity timer
    logic [3:0]          lowcnt;     // convert line low time while busy
    logic                prev_rc;
    logic                busy_n;
    logic [RESULT_W-1:0] result;
    logic                old_ok;     // previous result still valid
    logic                aborted;
    sadc_bus_t           bus;
  } sadc_st_t;

  sadc_st_t   st_r;
  sadc_st_t   st_nxt;
  sadc_pins_t pins;
  logic [2:0] pins_raw;

  // pins enter the clock domain through two flops
  sadc_sync #(
    .W(3)
  ) u_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({cs_n_in, rd_conv_in, byte_sel_in}),
    .rst_val_in (3'b111),
    .sync_out   (pins_raw)
  );
  assign pins = sadc_pins_t'(pins_raw);

  // byte lane view: high byte on the low lanes when byte_sel is high
  function automatic logic [RESULT_W-1:0] lane_view(input logic [RESULT_W-1:0] w,
                                                    input logic bsel);
    lane_view = bsel ? {w[BYTE_W-1:0], w[RESULT_W-1:BYTE_W]} : w;
  endfunction

  // control state machine and bus drive
  always_comb begin
    logic start;
    logic rd_en;
    start  = 1'b0;
    rd_en  = 1'b0;
    st_nxt = st_r;
    st_nxt.prev_rc = pins.rd_conv;
    st_nxt.aborted = 1'b0;
    // rd_conv falling while cs is low starts a conversion, cs falling does not
    start = !pins.cs_n && !pins.rd_conv && st_r.prev_rc;
    case (st_r.state)
      SADC_IDLE: begin
        if (!pins.cs_n && !pins.rd_conv && st_r.prev_rc) begin
          st_nxt.state  = SADC_CONV;
          st_nxt.busy_n = 1'b0;
          st_nxt.cnt    = '0;
          st_nxt.vcnt   = '0;
          st_nxt.lowcnt = 4'hF;  // the start pulse itself must not count as an abort
          st_nxt.old_ok = 1'b1;
        end
      end
      SADC_CONV: begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
        if (st_r.vcnt >= CNT_W'(VALID_CYC)) begin
          st_nxt.old_ok = 1'b0;
        end else begin
          st_nxt.vcnt = st_r.vcnt + CNT_W'(1);
        end
        // abort: convert line returned high then held low again
        if (pins.rd_conv) begin
          st_nxt.lowcnt = 4'hF;
        end else if (st_r.lowcnt != 4'hF && st_r.lowcnt != 4'hE) begin
          st_nxt.lowcnt = st_r.lowcnt;
        end
        if (!pins.rd_conv && st_r.prev_rc) begin
          st_nxt.lowcnt = 4'h0;
        end else if (!pins.rd_conv && st_r.lowcnt < 4'hE) begin
          st_nxt.lowcnt = st_r.lowcnt + 4'h1;
        end
        if (st_r.lowcnt < 4'hE &&
            st_r.lowcnt + 4'h1 >= 4'(CONVERT_PULSE_CYC)) begin
          st_nxt.state   = SADC_IDLE;
          st_nxt.busy_n  = 1'b1;
          st_nxt.aborted = 1'b1;
          st_nxt.old_ok  = 1'b1;                                // last finished result kept
        end else if (st_r.cnt + CNT_W'(1) >=
                     CNT_W'(CONV_CYC - DATA_TO_BUSY_CYC)) begin
          st_nxt.result = sample_in;
          st_nxt.old_ok = 1'b1;
          st_nxt.cnt    = '0;
          st_nxt.state  = SADC_PUBLISH;
        end
      end
      SADC_PUBLISH: begin
        // result is registered; hold busy low for the data setup time
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
        if (st_r.cnt + CNT_W'(1) >= CNT_W'(DATA_TO_BUSY_CYC)) begin
          st_nxt.busy_n = 1'b1;
          st_nxt.state  = SADC_IDLE;
        end
      end
      default: begin
        st_nxt.state  = SADC_IDLE;
        st_nxt.busy_n = 1'b1;
      end
    endcase
    // outputs live only with cs low and rd_conv high
    rd_en = !pins.cs_n && pins.rd_conv;
    st_nxt.bus.data = lane_view(st_nxt.result, pins.byte_sel);
    st_nxt.bus.oe   = (rd_en && st_nxt.old_ok) ? '1 : '0;
    if (start) begin
      st_nxt.bus.oe = '0;
    end
  end

  // single state register
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_r         <= '0;
      st_r.state   <= SADC_IDLE;
      st_r.busy_n  <= 1'b1;
      st_r.prev_rc <= 1'b1;
      st_r.lowcnt  <= 4'hF;
      st_r.result  <= RESULT_RST;
      st_r.old_ok  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_n_out  = st_r.busy_n;
  assign data_out    = st_r.bus.data;
  assign data_oe_out = st_r.bus.oe;
  assign aborted_out = st_r.aborted;
endmodule

//--- verif/sadc_chk.sv
// Purpose: pin timing checks for the readout block
// Assumes: two-flop pin sync, registered outputs
// Notes: bound to every readout instance
module sadc_chk
  import sadc_pkg::*;
#(
  parameter int unsigned CONV_CYC  = CONV_TIME_CYC,
  parameter int unsigned VALID_CYC = PREV_VALID_CYC
) (
  input wire logic                mclk_in,
  input wire logic                sys_rst_in,
  input wire logic                cs_n_in,
  input wire logic                rd_conv_in,
  input wire logic                byte_sel_in,
  input wire logic [RESULT_W-1:0] sample_in,
  input wire logic                busy_n_out,
  input wire logic [RESULT_W-1:0] data_out,
  input wire logic [RESULT_W-1:0] data_oe_out,
  input wire logic                aborted_out
);
  localparam int BUSY_MAX = CONV_CYC + 1;
  default clocking @(posedge mclk_in); endclocking
  // checks wait until the pin synchroniser has flushed after reset
  logic [1:0] warm_r;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end
  default disable iff (sys_rst_in || warm_r != 2'h3);
  // bus direction follows select and read level
  bus_off_a: assert property ((cs_n_in || !rd_conv_in) [*4]
    |-> data_oe_out == 16'h0000) else $error("bus driven while off");
  bus_on_a: assert property ((!cs_n_in && busy_n_out && rd_conv_in) [*4]
    |-> data_oe_out == 16'hFFFF) else $error("bus not driven");
  // busy timing against the convert line, result timing against busy
  busy_fall_a: assert property ($fell(rd_conv_in) && !cs_n_in && busy_n_out
    |-> ##[2:4] !busy_n_out) else $error("busy late");
  busy_max_a: assert property ($fell(busy_n_out) |-> ##[1:BUSY_MAX] busy_n_out)
    else $error("busy too long");
  data_early_a: assert property ($rose(busy_n_out)
    |-> data_out == $past(data_out, 4)) else $error("result too late");
  data_keep_a: assert property ($fell(busy_n_out) |-> $stable(data_out) [*8])
    else $error("old result lost");
  // abort by a long convert pulse while busy
  abort_pulse_a: assert property ($fell(rd_conv_in) && !cs_n_in && !busy_n_out
    ##1 !rd_conv_in [*5] |-> ##[0:4] aborted_out) else $error("no abort");
  abort_free_a: assert property (aborted_out |-> ##[0:1] busy_n_out)
    else $error("busy kept after abort");
endmodule
bind sadc_readout sadc_chk #(.CONV_CYC(CONV_CYC), .VALID_CYC(VALID_CYC)) u_chk (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n_in), .rd_conv_in(rd_conv_in),
  .byte_sel_in(byte_sel_in), .sample_in(sample_in), .busy_n_out(busy_n_out),
  .data_out(data_out), .data_oe_out(data_oe_out), .aborted_out(aborted_out));

//--- verif/sadc_host.sv
// Purpose: host latch that takes the result when busy rises
// Assumes: host samples the bus on mclk_in, the readout clock
// Notes: undriven lanes read back inverted
module sadc_host
  import sadc_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                busy_n_in,
  input  wire logic [RESULT_W-1:0] data_in,
  input  wire logic [RESULT_W-1:0] oe_in,
  output logic      [RESULT_W-1:0] cap_out
);
  logic busy_q;
  // strobe on busy rising, float lanes give garbage
  always_ff @(posedge mclk_in) begin
    busy_q <= busy_n_in;
    if (busy_n_in && !busy_q) begin
      cap_out <= (data_in & oe_in) | (~data_in & ~oe_in);
    end
  end
endmodule

//--- verif/sadc_readout_tb.sv
// Purpose: self-checking bench for the readout block
// Assumes: chip select low until the last test
// Notes: 20 cycle conversion, 10 cycle old-data window
module sadc_readout_tb
  import sadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                cs_n = 1'b0;
  logic                rdc = 1'b1;
  logic                bsel = 1'b0;
  logic                seen = 1'b0;
  logic [RESULT_W-1:0] smp = 16'h0000;
  logic                busy_n, abt;
  logic [RESULT_W-1:0] dat, oe, cap;
  int                  miscompares = 0;
  int                  num_checks = 0;
  // clock, design and host latch
  always #5 clk = ~clk;
  always @(posedge clk) if (abt === 1'b1) seen <= 1'b1;
  sadc_readout #(.CONV_CYC(20), .VALID_CYC(10)) u_dut (.mclk_in(clk), .sys_rst_in(rst),
    .cs_n_in(cs_n), .rd_conv_in(rdc), .byte_sel_in(bsel), .sample_in(smp),
    .busy_n_out(busy_n), .data_out(dat), .data_oe_out(oe), .aborted_out(abt));
  sadc_host u_host (.mclk_in(clk), .busy_n_in(busy_n), .data_in(dat), .oe_in(oe),
    .cap_out(cap));
  // compare one word
  task automatic chk(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counts, verdict and stop
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // convert line low for n cycles from this edge
  task automatic pulse(input int n);
    rdc <= 1'b0;
    repeat (n) @(posedge clk);
    rdc <= 1'b1;
  endtask
  // conversion with an early read, then word and byte reads
  task automatic conv(input logic [RESULT_W-1:0] code, input logic [RESULT_W-1:0] prev);
    int n;
    @(posedge clk);
    smp <= code;
    pulse(5);
    repeat (5) @(negedge clk);
    chk(oe, 16'hFFFF);
    chk(dat, prev);
    for (n = 0; n < 40 && busy_n !== 1'b1; n++) @(posedge clk);
    if (n == 40) begin
      miscompares++;
      give_verdict();
    end
    @(negedge clk);
    chk(cap, code);
    chk({15'h0000, seen}, 16'h0000);
    chk(dat, code);
    @(posedge clk);
    bsel <= 1'b1;
    repeat (5) @(negedge clk);
    chk({8'h00, dat[7:0]}, {8'h00, code[15:8]});
    @(posedge clk);
    bsel <= 1'b0;
    repeat (400) @(posedge clk);
    $display("conversion %h done", code);
  endtask
  // abort mid conversion, then lift select
  task automatic abort_run();
    @(posedge clk);
    smp <= 16'h1234;
    pulse(5);
    repeat (3) @(posedge clk);
    pulse(8);
    repeat (2) @(negedge clk);
    chk({15'h0000, seen}, 16'h0001);
    chk({15'h0000, busy_n}, 16'h0001);
    chk(dat, CODE_NEG_FS);
    repeat (400) @(posedge clk);
    chk(oe, 16'hFFFF);
    cs_n <= 1'b1;
    repeat (5) @(negedge clk);
    chk(oe, 16'h0000);
    $display("abort and select test done");
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    conv(CODE_POS_FS, RESULT_RST);
    conv(16'h0000, CODE_POS_FS);
    conv(16'hFFFF, 16'h0000);
    conv(CODE_NEG_FS, 16'hFFFF);
    abort_run();
    give_verdict();
  end
endmodule
